// file: rtl/rtcdm_pkg.sv
// rtcdm_pkg: constants for the date register and interrupt mask block
// assumes: 32-bit AXI4-Lite byte addresses, one aligned word per register
//
// What this block does
// - hundreds_of_years_field takes BCD 19-20 gregorian or 13-14 persian
// - year field takes any two-digit BCD value 00 through 99
// - month field takes BCD values 01 through 12
// - day-of-week takes BCD 1 through 7, meaning left to software
// - day-of-month field takes BCD values 01 through 31
// - multi-digit fields keep units in low nibble, tens above
// - undefined date register bits read back as zero
// - update_grant_irq_mask reads 1 while update-acknowledge interrupt enabled
// - alarm_irq_mask reads 1 while alarm interrupt enabled
// - one_hz_tick_irq_mask reads 1 while once-per-second interrupt enabled
// - clock_event_irq_mask reads 1 while time-event interrupt enabled
// - date_event_irq_mask reads 1 while date-event interrupt enabled

package rtcdm_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_DATE_SETTING = 32'h400E146C;
    localparam logic [31:0] ADDR_CAL_CTRL = 32'h400E1470;
    localparam logic [31:0] ADDR_IRQ_ENABLE_SET = 32'h400E1480;
    localparam logic [31:0] ADDR_IRQ_ENABLE_CLR = 32'h400E1484;
    localparam logic [31:0] ADDR_IRQ_ENABLE_VIEW = 32'h400E1488;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'h400E148C;

    // ------------------------------------------------------------
    // date_setting field positions
    // ------------------------------------------------------------
    localparam int HUNDREDS_OF_YEARS_FIELD_LSB = 0;
    localparam int HUNDREDS_OF_YEARS_FIELD_MSB = 6;
    localparam int YEAR_LSB = 8;
    localparam int YEAR_MSB = 15;
    localparam int MONTH_LSB = 16;
    localparam int MONTH_MSB = 20;
    localparam int WDAY_LSB = 21;
    localparam int WDAY_MSB = 23;
    localparam int MDAY_LSB = 24;
    localparam int MDAY_MSB = 29;
    localparam logic [31:0] DATE_FIELD_MASK = 32'h3FFFFF7F;

    // ------------------------------------------------------------
    // legal BCD ranges
    // ------------------------------------------------------------
    localparam logic [7:0] HUNDREDS_OF_YEARS_FIELD_GREG_LO = 8'h19;
    localparam logic [7:0] HUNDREDS_OF_YEARS_FIELD_GREG_HI = 8'h20;
    localparam logic [7:0] HUNDREDS_OF_YEARS_FIELD_PERS_LO = 8'h13;
    localparam logic [7:0] HUNDREDS_OF_YEARS_FIELD_PERS_HI = 8'h14;
    localparam logic [7:0] YEAR_LO = 8'h00;
    localparam logic [7:0] YEAR_HI = 8'h99;
    localparam logic [7:0] MONTH_LO = 8'h01;
    localparam logic [7:0] MONTH_HI = 8'h12;
    localparam logic [7:0] WDAY_LO = 8'h01;
    localparam logic [7:0] WDAY_HI = 8'h07;
    localparam logic [7:0] MDAY_LO = 8'h01;
    localparam logic [7:0] MDAY_HI = 8'h31;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] DATE_RESET = 32'h01210020;
    localparam logic [4:0] IRQ_ENABLE_RESET = 5'h00;
    localparam logic [4:0] IRQ_STATUS_RESET = 5'h00;
    localparam logic CAL_PERSIAN_RESET = 1'b0;

    // ------------------------------------------------------------
    // interrupt bit positions, shared by mask and status
    // ------------------------------------------------------------
    localparam int IRQ_NUM = 5;
    localparam int IRQ_UPDATE_GRANT = 0;
    localparam int IRQ_ALARM = 1;
    localparam int IRQ_ONE_HZ_TICK = 2;
    localparam int IRQ_CLOCK_EVENT = 3;
    localparam int IRQ_DATE_EVENT = 4;
    localparam int CAL_PERSIAN_BIT = 0;

    // ------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rtcdm_pkg

// file: rtl/rtcdm_date_check.sv
// rtcdm_date_check: legality test of a candidate date_setting word
// assumes: purely combinational, fed from the bus write path
`timescale 1ns/1ps
`default_nettype none

module rtcdm_date_check (
    input wire logic [31:0] date_word,
    input wire logic persian_mode,
    output logic date_ok
);

    // ------------------------------------------------------------
    // bcd digit and range test
    // ------------------------------------------------------------
    function automatic logic bcd_in_range(
        input logic [7:0] v,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        bcd_in_range = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
    endfunction : bcd_in_range

    logic [7:0] hundreds_of_years_field_v;
    logic [7:0] year_v;
    logic [7:0] month_v;
    logic [7:0] wday_v;
    logic [7:0] mday_v;
    logic hundreds_of_years_field_ok;

    // units in low nibble, tens above
    assign hundreds_of_years_field_v = {1'b0, date_word[rtcdm_pkg::HUNDREDS_OF_YEARS_FIELD_MSB:rtcdm_pkg::HUNDREDS_OF_YEARS_FIELD_LSB]};
    assign year_v = date_word[rtcdm_pkg::YEAR_MSB:rtcdm_pkg::YEAR_LSB];
    assign month_v = {3'h0, date_word[rtcdm_pkg::MONTH_MSB:rtcdm_pkg::MONTH_LSB]};
    assign wday_v = {5'h00, date_word[rtcdm_pkg::WDAY_MSB:rtcdm_pkg::WDAY_LSB]};
    assign mday_v = {2'h0, date_word[rtcdm_pkg::MDAY_MSB:rtcdm_pkg::MDAY_LSB]};

    assign hundreds_of_years_field_ok = persian_mode ?
        bcd_in_range(hundreds_of_years_field_v, rtcdm_pkg::HUNDREDS_OF_YEARS_FIELD_PERS_LO, rtcdm_pkg::HUNDREDS_OF_YEARS_FIELD_PERS_HI) :
        bcd_in_range(hundreds_of_years_field_v, rtcdm_pkg::HUNDREDS_OF_YEARS_FIELD_GREG_LO, rtcdm_pkg::HUNDREDS_OF_YEARS_FIELD_GREG_HI);

    assign date_ok = hundreds_of_years_field_ok
        && bcd_in_range(year_v, rtcdm_pkg::YEAR_LO, rtcdm_pkg::YEAR_HI)
        && bcd_in_range(month_v, rtcdm_pkg::MONTH_LO, rtcdm_pkg::MONTH_HI)
        && bcd_in_range(wday_v, rtcdm_pkg::WDAY_LO, rtcdm_pkg::WDAY_HI)
        && bcd_in_range(mday_v, rtcdm_pkg::MDAY_LO, rtcdm_pkg::MDAY_HI);

endmodule : rtcdm_date_check

`default_nettype wire

// file: rtl/rtcdm_top.sv
// rtcdm_top: date register, interrupt enables, sticky status, AXI4-Lite slave
// assumes: one master, one write and one read at a time, events are one-cycle pulses
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module rtcdm_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic update_grant_event,
    input wire logic alarm_event,
    input wire logic one_hz_tick_event,
    input wire logic clock_event,
    input wire logic date_event,
    output logic [31:0] date_value,
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] date_r;
    logic persian_r;
    logic [rtcdm_pkg::IRQ_NUM-1:0] irq_enable_r;
    logic [rtcdm_pkg::IRQ_NUM-1:0] irq_status_r;
    logic [rtcdm_pkg::IRQ_NUM-1:0] irq_status_nxt;
    logic [rtcdm_pkg::IRQ_NUM-1:0] irq_events;
    logic [31:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic irq_r;

    logic aw_take;
    logic w_take;
    logic wr_go;
    logic ar_take;
    logic [31:0] date_merged;
    logic date_ok;
    logic status_read_clear;
    logic [31:0] rd_value;
    logic rd_mapped;
    logic wr_mapped;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic addr_mapped(input logic [31:0] a);
        addr_mapped = (a == rtcdm_pkg::ADDR_DATE_SETTING)
            || (a == rtcdm_pkg::ADDR_CAL_CTRL)
            || (a == rtcdm_pkg::ADDR_IRQ_ENABLE_SET)
            || (a == rtcdm_pkg::ADDR_IRQ_ENABLE_CLR)
            || (a == rtcdm_pkg::ADDR_IRQ_ENABLE_VIEW)
            || (a == rtcdm_pkg::ADDR_IRQ_STATUS);
    endfunction : addr_mapped

    function automatic logic [31:0] strb_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        strb_merge = m;
    endfunction : strb_merge

    // ------------------------------------------------------------
    // write channel handshakes
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;
    assign wr_mapped = addr_mapped(awaddr_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 32'h00000000;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= rtcdm_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_mapped ? rtcdm_pkg::RESP_OKAY : rtcdm_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ------------------------------------------------------------
    // date register
    // ------------------------------------------------------------
    assign date_merged = strb_merge(date_r, wdata_r, wstrb_r) & rtcdm_pkg::DATE_FIELD_MASK;

    rtcdm_date_check u_check (
        .date_word(date_merged),
        .persian_mode(persian_r),
        .date_ok(date_ok)
    );

    // illegal candidates leave the stored date untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            date_r <= rtcdm_pkg::DATE_RESET;
        end else if (wr_go && awaddr_r == rtcdm_pkg::ADDR_DATE_SETTING && date_ok) begin
            date_r <= date_merged;
        end
    end

    assign date_value = date_r;

    // ------------------------------------------------------------
    // calendar selection
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            persian_r <= rtcdm_pkg::CAL_PERSIAN_RESET;
        end else if (wr_go && awaddr_r == rtcdm_pkg::ADDR_CAL_CTRL && wstrb_r[0]) begin
            persian_r <= wdata_r[rtcdm_pkg::CAL_PERSIAN_BIT];
        end
    end

    // ------------------------------------------------------------
    // interrupt enables, set and clear ports
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_r <= rtcdm_pkg::IRQ_ENABLE_RESET;
        end else if (wr_go && wstrb_r[0]) begin
            if (awaddr_r == rtcdm_pkg::ADDR_IRQ_ENABLE_SET) begin
                irq_enable_r <= irq_enable_r | wdata_r[rtcdm_pkg::IRQ_NUM-1:0];
            end else if (awaddr_r == rtcdm_pkg::ADDR_IRQ_ENABLE_CLR) begin
                irq_enable_r <= irq_enable_r & ~wdata_r[rtcdm_pkg::IRQ_NUM-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // sticky status, cleared by read, set wins
    // ------------------------------------------------------------
    assign irq_events[rtcdm_pkg::IRQ_UPDATE_GRANT] = update_grant_event;
    assign irq_events[rtcdm_pkg::IRQ_ALARM] = alarm_event;
    assign irq_events[rtcdm_pkg::IRQ_ONE_HZ_TICK] = one_hz_tick_event;
    assign irq_events[rtcdm_pkg::IRQ_CLOCK_EVENT] = clock_event;
    assign irq_events[rtcdm_pkg::IRQ_DATE_EVENT] = date_event;

    assign status_read_clear = ar_take && (s_axi_araddr == rtcdm_pkg::ADDR_IRQ_STATUS);

    // events are recorded whatever the enables say
    assign irq_status_nxt = (status_read_clear ? rtcdm_pkg::IRQ_STATUS_RESET : irq_status_r)
        | irq_events;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_r <= rtcdm_pkg::IRQ_STATUS_RESET;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_status_nxt & irq_enable_r);
        end
    end

    assign irq = irq_r;

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_r;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_mapped = addr_mapped(s_axi_araddr);

    always_comb begin
        rd_value = 32'h00000000;
        unique case (s_axi_araddr)
            rtcdm_pkg::ADDR_DATE_SETTING: begin
                rd_value = date_r & rtcdm_pkg::DATE_FIELD_MASK;
            end
            rtcdm_pkg::ADDR_CAL_CTRL: begin
                rd_value[rtcdm_pkg::CAL_PERSIAN_BIT] = persian_r;
            end
            rtcdm_pkg::ADDR_IRQ_ENABLE_VIEW: begin
                rd_value[rtcdm_pkg::IRQ_NUM-1:0] = irq_enable_r;
            end
            rtcdm_pkg::ADDR_IRQ_STATUS: begin
                rd_value[rtcdm_pkg::IRQ_NUM-1:0] = irq_status_r;
            end
            default: begin
                rd_value = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= rtcdm_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_value;
            rresp_r <= rd_mapped ? rtcdm_pkg::RESP_OKAY : rtcdm_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

endmodule : rtcdm_top

`default_nettype wire

// file: tb/rtcdm_top_monitor.sv
// rtcdm_top_monitor: port-level checks of rtcdm_top
// assumes: bound to rtcdm_top, package compiled first
`timescale 1ns/1ps
`default_nettype none

module rtcdm_top_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic update_grant_event,
    input wire logic alarm_event,
    input wire logic one_hz_tick_event,
    input wire logic clock_event,
    input wire logic date_event,
    input wire logic [31:0] date_value,
    input wire logic irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [4:0] ev;
    logic [7:0] hundreds_of_years_field;
    assign ev = {date_event, clock_event, one_hz_tick_event, alarm_event, update_grant_event};
    assign hundreds_of_years_field = {1'b0, date_value[6:0]};

    function automatic logic bok(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
        return v[3:0] <= 4'h9 && v[7:4] <= 4'h9 && v >= lo && v <= hi;
    endfunction : bok

    hundreds_of_years_field_range_a: assert property (bok(hundreds_of_years_field, 8'h19, 8'h20) || bok(hundreds_of_years_field, 8'h13, 8'h14))
        else $error("century field out of range");
    year_bcd_a: assert property (bok(date_value[15:8], 8'h00, 8'h99))
        else $error("year field not bcd");
    month_range_a: assert property (bok({3'h0, date_value[20:16]}, 8'h01, 8'h12))
        else $error("month field out of range");
    wday_range_a: assert property (bok({5'h0, date_value[23:21]}, 8'h01, 8'h07))
        else $error("weekday field out of range");
    mday_range_a: assert property (bok({2'h0, date_value[29:24]}, 8'h01, 8'h31))
        else $error("day field out of range");
    resv_zero_a: assert property ((date_value & ~rtcdm_pkg::DATE_FIELD_MASK) == 32'h0)
        else $error("reserved date bits set");
    date_by_write_a: assert property (!$stable(date_value) |-> $rose(s_axi_bvalid))
        else $error("date changed without write response");
    irq_cause_a: assert property ($rose(irq) |-> $past(|ev) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("irq rose without cause");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");

    cover property ($rose(s_axi_bvalid));
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(irq));
endmodule : rtcdm_top_monitor

bind rtcdm_top rtcdm_top_monitor rtcdm_top_monitor_i (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .update_grant_event, .alarm_event, .one_hz_tick_event, .clock_event, .date_event,
    .date_value, .irq);

`default_nettype wire

// file: tb/tb_rtcdm_top.sv
// tb_rtcdm_top: self-checking bench of rtcdm_top with a behavioural model
// assumes: package and monitor compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_rtcdm_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, pers_m;
    logic [31:0] awaddr, wdata, araddr, rdata, date_value, rng, date_m;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [4:0] ev, en_m;
    logic [7:0] ctab [8] = '{8'h19, 8'h20, 8'h13, 8'h14, 8'h21, 8'h18, 8'h1A, 8'h12};
    int fail_count, total_checks;

    rtcdm_top rtcdm_top_i (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .update_grant_event(ev[0]), .alarm_event(ev[1]), .one_hz_tick_event(ev[2]),
        .clock_event(ev[3]), .date_event(ev[4]), .date_value, .irq);

    // ------------------------------------------------------------
    // model helpers and bus tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    function automatic logic [7:0] bcd(int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction : bcd
    function automatic logic bok(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
        return v[3:0] <= 4'h9 && v[7:4] <= 4'h9 && v >= lo && v <= hi;
    endfunction : bok
    function automatic logic date_ok(logic [31:0] d);
        logic [7:0] c;
        c = {1'b0, d[6:0]};
        return (pers_m ? bok(c, 8'h13, 8'h14) : bok(c, 8'h19, 8'h20))
            && bok(d[15:8], 8'h00, 8'h99) && bok({3'h0, d[20:16]}, 8'h01, 8'h12)
            && bok({5'h0, d[23:21]}, 8'h01, 8'h07) && bok({2'h0, d[29:24]}, 8'h01, 8'h31);
    endfunction : date_ok
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(logic [31:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                chk({30'h0, bresp}, {30'h0, er});
            end
        end
        bready <= 1'b0;
    endtask : wr
    task automatic rd(logic [31:0] a, logic [1:0] er, output logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                d = rdata;
                chk({30'h0, rresp}, {30'h0, er});
            end
        end
        rready <= 1'b0;
    endtask : rd
    task automatic tally_and_finish();
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] d, cand, sm;
        logic [7:0] y, m, dd;
        logic [3:0] s;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ev, en_m, pers_m} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        rng = 32'hA4758714;
        date_m = rtcdm_pkg::DATE_RESET;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(rtcdm_pkg::ADDR_DATE_SETTING, rtcdm_pkg::RESP_OKAY, d);
        chk(d, date_m);
        wr(rtcdm_pkg::ADDR_DATE_SETTING, 32'hC1219999, 4'hF, rtcdm_pkg::RESP_OKAY);
        rd(rtcdm_pkg::ADDR_DATE_SETTING, rtcdm_pkg::RESP_OKAY, d);
        chk(d & ~rtcdm_pkg::DATE_FIELD_MASK, 32'h0);
        wr(rtcdm_pkg::ADDR_DATE_SETTING, date_m, 4'hF, rtcdm_pkg::RESP_OKAY);
        wr(rtcdm_pkg::ADDR_DATE_SETTING + 32'h1000, 32'hFFFFFFFF, 4'hF, rtcdm_pkg::RESP_SLVERR);
        rd(rtcdm_pkg::ADDR_DATE_SETTING + 32'h1000, rtcdm_pkg::RESP_SLVERR, d);
        chk(d, 32'h0);
        for (int n = 0; n < 60; n++) begin
            rng = xs(rng);
            if (rng[29]) begin
                pers_m = rng[30];
                wr(rtcdm_pkg::ADDR_CAL_CTRL, {31'h0, pers_m}, 4'hF, rtcdm_pkg::RESP_OKAY);
                rd(rtcdm_pkg::ADDR_CAL_CTRL, rtcdm_pkg::RESP_OKAY, d);
                chk(d, {31'h0, pers_m});
            end
            y = rng[20] ? rng[7:0] : bcd(int'(rng % 100));
            m = bcd(int'((rng >> 8) % 13));
            dd = bcd(int'((rng >> 12) % 32));
            cand = {2'h0, dd[5:0], 3'((rng >> 17) % 8), m[4:0], y, ctab[rng[23:21]]};
            s = rng[28] ? rng[27:24] : 4'hF;
            sm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
            d = (date_m & ~sm) | (cand & sm);
            if (date_ok(d)) date_m = d & rtcdm_pkg::DATE_FIELD_MASK;
            wr(rtcdm_pkg::ADDR_DATE_SETTING, cand, s, rtcdm_pkg::RESP_OKAY);
            rd(rtcdm_pkg::ADDR_DATE_SETTING, rtcdm_pkg::RESP_OKAY, d);
            chk(d, date_m);
            chk(date_value, date_m);
        end
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 2; k++) begin
                wr(k == 0 ? rtcdm_pkg::ADDR_IRQ_ENABLE_SET : rtcdm_pkg::ADDR_IRQ_ENABLE_CLR,
                    32'h1 << i, 4'hF, rtcdm_pkg::RESP_OKAY);
                en_m[i] = (k == 0);
                rd(rtcdm_pkg::ADDR_IRQ_ENABLE_VIEW, rtcdm_pkg::RESP_OKAY, d);
                chk(d, {27'h0, en_m});
                @(posedge aclk);
                ev <= 5'h1 << i;
                @(posedge aclk);
                ev <= 5'h0;
                repeat (2) @(posedge aclk);
                chk({31'h0, irq}, {31'h0, en_m[i]});
                rd(rtcdm_pkg::ADDR_IRQ_STATUS, rtcdm_pkg::RESP_OKAY, d);
                chk(d, 32'h1 << i);
                repeat (2) @(posedge aclk);
                chk({31'h0, irq}, 32'h0);
            end
        end
        wr(rtcdm_pkg::ADDR_IRQ_ENABLE_VIEW, 32'h1F, 4'hF, rtcdm_pkg::RESP_OKAY);
        rd(rtcdm_pkg::ADDR_IRQ_ENABLE_VIEW, rtcdm_pkg::RESP_OKAY, d);
        chk(d, {27'h0, en_m});
        rd(rtcdm_pkg::ADDR_IRQ_ENABLE_SET, rtcdm_pkg::RESP_OKAY, d);
        chk(d, 32'h0);
        tally_and_finish();
    end
endmodule : tb_rtcdm_top

`default_nettype wire
